// ===== hw/ebsc_regs.sv
// Purpose: settings register file for the state controller
// Assumes: byte-wide write strobe from the serial port logic
// Notes: settings survive until reset, i.e. supply loss
`timescale 1ns/1ns
`include "ebsc_map.svh"
module ebsc_regs (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic [6:0] wr_addr,
    input wire logic [7:0] wr_data,
    ebsc_cfg_if.regs cfg
);
    logic [7:0] cmd_reg; // Command byte
    logic [7:0] prof_reg; // Profile low byte
    logic [7:0] first_setting_register_reg; // Output level
    logic [7:0] set2_reg; // Current and floor
    logic [7:0] set3_reg; // Target and auto
    logic [7:0] set4_reg; // Warning and ceiling
    // Write decode, accepted in any state
    wire logic wr_cmd = wr_en && (wr_addr == `EBSC_ADDR_COMMAND); // [RULE3]
    wire logic wr_prof = wr_en && (wr_addr == `EBSC_ADDR_PROFILE_LO);
    wire logic wr_s1 = wr_en && (wr_addr == `EBSC_ADDR_FIRST_SETTING_REGISTER);
    wire logic wr_s2 = wr_en && (wr_addr == `EBSC_ADDR_SET2);
    wire logic wr_s3 = wr_en && (wr_addr == `EBSC_ADDR_SET3);
    wire logic wr_s4 = wr_en && (wr_addr == `EBSC_ADDR_SET4);
    // Registers held until supply loss resets them
    always_ff @(posedge clock) begin
        if (!rst_n) begin // [RULE4]
            cmd_reg <= 8'h00;
            prof_reg <= 8'h00;
            first_setting_register_reg <= `EBSC_FIRST_SETTING_REGISTER_RESET;
            set2_reg <= `EBSC_SET2_RESET;
            set3_reg <= `EBSC_SET3_RESET;
            set4_reg <= `EBSC_SET4_RESET; // [RULE24]
        end else begin
            if (wr_cmd) cmd_reg <= wr_data;
            if (wr_prof) prof_reg <= wr_data;
            if (wr_s1) first_setting_register_reg <= wr_data;
            if (wr_s2) set2_reg <= wr_data;
            if (wr_s3) set3_reg <= wr_data;
            if (wr_s4) set4_reg <= wr_data;
        end
    end
    // Field extraction
    assign cfg.demand_enable = cmd_reg[`EBSC_CMD_EOD];
    assign cfg.continuous_enable = cmd_reg[`EBSC_CMD_ECM];
    assign cfg.force_active = cmd_reg[`EBSC_CMD_ACT];
    assign cfg.profile = {prof_reg[1:0], cmd_reg[7:4]};
    assign cfg.output_level_sel = first_setting_register_reg[3:0];
    assign cfg.charge_current_sel = set2_reg[7:5]; // [RULE8]
    assign cfg.battery_floor_sel = set2_reg[2:0]; // [RULE10]
    assign cfg.fixed_target_sel = set3_reg[3:0];
    assign cfg.pin_trigger_select = set3_reg[`EBSC_SET3_AUTO];
    assign cfg.storage_ceiling_sel = set4_reg[`EBSC_SET4_CEIL];
    assign cfg.warning_enable = set4_reg[`EBSC_SET4_WARN_EN];
    assign cfg.warning_threshold = set3_reg[7:4];
endmodule // ebsc_regs

// ===== hw/ebsc_top.sv
// Purpose: operating-state controller for a battery energy buffer
// Assumes: 50 MHz clock; analog compare results arrive as asynchronous levels
// Notes: registers reached over the documented byte port (write strobe, read addr)
`timescale 1ns/1ns
`include "ebsc_map.svh"
module ebsc_top #(
    parameter int STARTUP_CYCLES = `EBSC_STARTUP_MS * 1000 * `EBSC_CLK_MHZ,
    parameter int WARN_CYCLES = `EBSC_WARN_PULSE_US * `EBSC_CLK_MHZ
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic [6:0] reg_addr,
    input wire logic [7:0] wr_data,
    output logic [7:0] rd_data,
    input wire logic start_pin,
    input wire logic battery_low,
    input wire logic [4:0] storage_code,
    input wire logic [3:0] learned_target,
    input wire logic regulated_ok,
    output logic power_good,
    output logic supply_from_battery,
    output logic boost_enable,
    output logic [2:0] boost_current,
    output logic [3:0] charge_target,
    output logic regulator_enable,
    output logic [3:0] regulator_level,
    output logic [2:0] floor_level
);
    localparam int FLOOR_CYCLES = (`EBSC_FLOOR_NS * `EBSC_CLK_MHZ + 999) / 1000;
    ebsc_cfg_if cfg ();
    ebsc_pkg::ebsc_state_t state_reg, state_next;
    logic [2:0] start_sync, bat_sync; // Three-stage pin synchronisers
    logic start_seen_reg; // Last agreed start level
    logic bat_low_reg; // Agreed battery-low level
    logic [31:0] boot_cnt_reg; // Startup timer
    logic [15:0] floor_cnt_reg; // Floor breach timer
    logic [31:0] warn_cnt_reg; // Warning pulse timer
    logic weak_reg, warn_reg, warn_prev_reg; // Status flags
    logic [4:0] level_reg; // Captured capacitor code
    logic ready_reg; // Ready level
    // Settings registers
    ebsc_regs u_regs (
        .clock(clock),
        .rst_n(rst_n),
        .wr_en(wr_en),
        .wr_addr(reg_addr),
        .wr_data(wr_data),
        .cfg(cfg)
    );
    // Pin synchronisers
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            start_sync <= 3'h0;
            bat_sync <= 3'h0;
        end else begin
            start_sync <= {start_sync[1:0], start_pin};
            bat_sync <= {bat_sync[1:0], battery_low};
        end
    end
    // Agreed levels once stages two and three match
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            start_seen_reg <= 1'b0;
            bat_low_reg <= 1'b0;
        end else begin
            if (start_sync[1] == start_sync[2]) start_seen_reg <= start_sync[2];
            if (bat_sync[1] == bat_sync[2]) bat_low_reg <= bat_sync[2];
        end
    end
    wire logic start_rise = (start_sync[1] == start_sync[2]) && start_sync[2] && !start_seen_reg;
    // End-of-charge target selection
    // Learned target comes straight from the optimizer pins, not the settings bundle
    wire logic [3:0] chosen_target = (cfg.profile == 6'h00) ? cfg.fixed_target_sel
                                                           : learned_target; // [RULE12]
    // Ceiling code chosen by the ceiling select bit
    wire logic [3:0] ceiling = cfg.storage_ceiling_sel ? `EBSC_CEIL_HIGH : `EBSC_CEIL_LOW;
    wire logic [3:0] eff_target = (chosen_target > ceiling) ? ceiling : chosen_target; // [RULE13]
    wire logic target_hit = (storage_code[4:1] >= eff_target);
    wire logic cap_low = (storage_code[4:1] < cfg.warning_threshold);
    wire logic boot_done = (boot_cnt_reg >= 32'(STARTUP_CYCLES - 1));
    // Next-state decode
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ebsc_pkg::EBSC_STARTUP: begin
                if (boot_done) state_next = ebsc_pkg::EBSC_STANDBY; // [RULE1]
            end
            ebsc_pkg::EBSC_STANDBY: begin
                if (cfg.demand_enable || cfg.continuous_enable ||
                    (cfg.pin_trigger_select && start_rise)) begin
                    state_next = ebsc_pkg::EBSC_CHARGE; // [RULE6]
                end
            end
            ebsc_pkg::EBSC_CHARGE: begin
                if (!cfg.demand_enable && !cfg.continuous_enable && !cfg.force_active
                    && !cfg.pin_trigger_select) begin
                    state_next = ebsc_pkg::EBSC_STANDBY; // [RULE21]
                end else if (cfg.continuous_enable) begin
                    if (cfg.force_active) state_next = ebsc_pkg::EBSC_ACTIVE; // [RULE20]
                    // Otherwise keep topping up [RULE16]
                end else if (cfg.force_active) begin
                    state_next = ebsc_pkg::EBSC_ACTIVE; // [RULE18]
                end else if (target_hit) begin
                    state_next = ebsc_pkg::EBSC_ACTIVE; // [RULE15]
                end
            end
            ebsc_pkg::EBSC_ACTIVE: begin
                if (cfg.continuous_enable) begin
                    if (!cfg.force_active) state_next = ebsc_pkg::EBSC_CHARGE; // [RULE20]
                end else if (!cfg.demand_enable && !cfg.force_active) begin
                    state_next = ebsc_pkg::EBSC_STANDBY; // [RULE19] [RULE21]
                end
            end
        endcase
    end
    // State register
    always_ff @(posedge clock) begin
        if (!rst_n) state_reg <= ebsc_pkg::EBSC_STARTUP;
        else state_reg <= state_next;
    end
    // Startup timer
    always_ff @(posedge clock) begin
        if (!rst_n) boot_cnt_reg <= 32'h0;
        else if (!boot_done) boot_cnt_reg <= boot_cnt_reg + 32'h1;
    end
    // Floor breach timer and weak flag, flag cleared on new charge start
    wire logic in_charge = (state_reg == ebsc_pkg::EBSC_CHARGE);
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            floor_cnt_reg <= 16'h0;
            weak_reg <= 1'b0;
        end else begin
            if (in_charge && bat_low_reg) begin
                if (floor_cnt_reg != 16'hffff) floor_cnt_reg <= floor_cnt_reg + 16'h1;
            end else begin
                floor_cnt_reg <= 16'h0;
            end
            if (in_charge && bat_low_reg && floor_cnt_reg >= 16'(FLOOR_CYCLES)) begin
                weak_reg <= 1'b1; // [RULE11]
            end else if (state_next == ebsc_pkg::EBSC_CHARGE && !in_charge) begin
                weak_reg <= 1'b0;
            end
        end
    end
    // Early warning flag and low pulse on its rise
    wire logic in_active = (state_reg == ebsc_pkg::EBSC_ACTIVE);
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            warn_reg <= 1'b0;
            warn_prev_reg <= 1'b0;
            warn_cnt_reg <= 32'h0;
        end else begin
            warn_prev_reg <= warn_reg;
            if (in_active && cfg.warning_enable && cap_low) warn_reg <= 1'b1; // [RULE22] [RULE24]
            else if (!in_active) warn_reg <= 1'b0;
            if (warn_reg && !warn_prev_reg) warn_cnt_reg <= 32'(WARN_CYCLES); // [RULE23]
            else if (warn_cnt_reg != 32'h0) warn_cnt_reg <= warn_cnt_reg - 32'h1;
        end
    end
    // Ready level and capacitor code capture
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ready_reg <= 1'b0;
            level_reg <= 5'h00;
        end else begin
            if (in_charge || in_active) level_reg <= storage_code; // [RULE14]
            if (!in_active) ready_reg <= 1'b0; // [RULE5]
            else if (cfg.continuous_enable) ready_reg <= target_hit || ready_reg;
            else ready_reg <= (target_hit && regulated_ok) || ready_reg; // [RULE25]
        end
    end
    // Output and readback registers
    wire logic charging_now = in_charge && !bat_low_reg && !target_hit; // [RULE10]
    wire logic [7:0] cond_word = {1'b0, warn_reg, 1'b0, weak_reg, 3'h0, ready_reg};
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rd_data <= 8'h00;
            power_good <= 1'b0;
            supply_from_battery <= 1'b1;
            boost_enable <= 1'b0;
            boost_current <= 3'h0;
            charge_target <= 4'h0;
            regulator_enable <= 1'b0;
            regulator_level <= 4'h0;
            floor_level <= 3'h0;
        end else begin
            unique case (reg_addr)
                `EBSC_ADDR_CONDITION: rd_data <= cond_word;
                `EBSC_ADDR_STORAGE: rd_data <= {3'h0, level_reg};
                default: rd_data <= 8'h00;
            endcase
            power_good <= ready_reg && (warn_cnt_reg == 32'h0); // [RULE5] [RULE23]
            supply_from_battery <= !in_active; // [RULE1] [RULE17]
            boost_enable <= charging_now; // [RULE8] [RULE16]
            boost_current <= (cfg.charge_current_sel > `EBSC_ICH_MAX) ? `EBSC_ICH_MAX
                                                                    : cfg.charge_current_sel; // [RULE9]
            charge_target <= eff_target;
            regulator_enable <= in_active; // [RULE17]
            regulator_level <= cfg.output_level_sel;
            floor_level <= cfg.battery_floor_sel; // [RULE9]
        end
    end
endmodule // ebsc_top

// ===== inc/ebsc_cfg_if.sv
// Purpose: settings bundle from register file to state core
// Assumes: single clock
// Notes: plain signals, modports per side
`timescale 1ns/1ns
interface ebsc_cfg_if;
    logic demand_enable; // On-demand mode
    logic continuous_enable; // Continuous mode
    logic force_active; // Force-active bit
    logic pin_trigger_select; // Auto mode
    logic warning_enable; // Early warning on
    logic storage_ceiling_sel; // Ceiling choice
    logic [2:0] charge_current_sel; // Charge current code
    logic [2:0] battery_floor_sel; // Battery floor code
    logic [3:0] fixed_target_sel; // Fixed end-of-charge
    logic [3:0] output_level_sel; // Active output level
    logic [3:0] warning_threshold; // Warning level
    logic [5:0] profile; // Optimizer profile
    modport regs (output demand_enable, continuous_enable, force_active, pin_trigger_select,
        warning_enable, storage_ceiling_sel, charge_current_sel, battery_floor_sel,
        fixed_target_sel, output_level_sel, warning_threshold, profile);
    modport core (input demand_enable, continuous_enable, force_active, pin_trigger_select,
        warning_enable, storage_ceiling_sel, charge_current_sel, battery_floor_sel,
        fixed_target_sel, output_level_sel, warning_threshold, profile);
endinterface

// ===== inc/ebsc_map.svh
// Purpose: register offsets, field positions, reset values and timing for the state controller
// Assumes: 50 MHz clock, byte-wide register port
// Notes: register map and constants only
// Notes on behaviour
// RULE1: Power-on connects supplies, Standby after 20 ms
// RULE2: Host waits 20 ms before bus access
// RULE3: Standby keeps register port live, accepts settings
// RULE4: Registers hold while battery supply stays
// RULE5: power_good low throughout Standby
// RULE6: Standby to Charge on demand, continuous, start
// RULE7: Host start pulse about 10 us
// RULE8: Charge boosts at current from bits 7:5
// RULE9: Codes 0-3 normal, 4 emergency, floor kept
// RULE10: Charging pauses below battery floor, resumes later
// RULE11: Floor breach over 16 us sets weak flag
// RULE12: Profile zero uses fixed target, else learned
// RULE13: Capacitor never exceeds selected ceiling voltage
// RULE14: Five-bit capacitor code in register 0x05
// RULE15: On-demand goes Active when target reached
// RULE16: Continuous stays in Charge topping up
// RULE17: Active supplies outputs from regulator at level
// RULE18: On-demand force-active enters Active early
// RULE19: On-demand clearing demand returns to Standby
// RULE20: Continuous force-active toggles Active and Charge
// RULE21: Clearing continuous and force returns Standby
// RULE22: Warning flag when enabled and capacitor low
// RULE23: Warning rise pulses power_good low briefly
// RULE24: Warning enable resets to disabled
// RULE25: On-demand power_good high at target and regulated
`ifndef EBSC_MAP_SVH
`define EBSC_MAP_SVH
`define EBSC_ADDR_CONDITION 7'h00
`define EBSC_ADDR_STORAGE 7'h05
`define EBSC_ADDR_PROFILE_LO 7'h07
`define EBSC_ADDR_COMMAND 7'h08
`define EBSC_ADDR_FIRST_SETTING_REGISTER 7'h09
`define EBSC_ADDR_SET2 7'h0a
`define EBSC_ADDR_SET3 7'h0b
`define EBSC_ADDR_SET4 7'h0c
`define EBSC_CMD_ACT 2
`define EBSC_CMD_ECM 1
`define EBSC_CMD_EOD 0
`define EBSC_ST_READY 0
`define EBSC_ST_WEAK 4
`define EBSC_ST_WARN 6
`define EBSC_SET4_CEIL 4
`define EBSC_SET4_WARN_EN 5
`define EBSC_SET3_AUTO 7
`define EBSC_FIRST_SETTING_REGISTER_RESET 8'h0a
`define EBSC_SET2_RESET 8'h00
`define EBSC_SET3_RESET 8'h00
`define EBSC_SET4_RESET 8'h00
`define EBSC_ICH_MAX 3'h4
`define EBSC_CEIL_LOW 4'hb
`define EBSC_CEIL_HIGH 4'hf
`define EBSC_STARTUP_MS 20
`define EBSC_FLOOR_NS 16000
`define EBSC_WARN_PULSE_US 100
`define EBSC_CLK_MHZ 50
`endif

// ===== inc/ebsc_pkg.sv
// Purpose: types shared by the state controller files
// Assumes: nothing
// Notes: one-hot state codes
package ebsc_pkg;
    typedef enum logic [3:0] {
        EBSC_STARTUP = 4'h1,
        EBSC_STANDBY = 4'h2,
        EBSC_CHARGE = 4'h4,
        EBSC_ACTIVE = 4'h8
    } ebsc_state_t;
endpackage

// ===== verification/ebsc_host.sv
// Purpose: host controller model driving the register port and start pin
// Assumes: inputs change 2 ns after the rising edge
// Notes: released write data is inverted so it never lingers
`timescale 1ns/1ns
module ebsc_host (
    input wire logic clock,
    input wire logic [7:0] rd_data,
    output logic wr_en,
    output logic [6:0] reg_addr,
    output logic [7:0] wr_data,
    output logic start_pin
);
    // Idle values at time zero
    initial begin
        wr_en = 1'b0;
        reg_addr = 7'h01;
        wr_data = 8'h00;
        start_pin = 1'b0;
    end
    // Hold off all access through startup
    task automatic boot(input int n);
        repeat (n + 4) @(posedge clock);
        #2;
    endtask
    // One-cycle write strobe
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge clock);
        #2;
        wr_en = 1'b1;
        reg_addr = a;
        wr_data = d;
        @(posedge clock);
        #2;
        wr_en = 1'b0;
        wr_data = ~d;
    endtask
    // Read data lands one cycle after the address
    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        @(posedge clock);
        #2;
        reg_addr = a;
        @(posedge clock);
        #2;
        d = rd_data;
    endtask
    // Start pulse of about 10 us
    task automatic pulse();
        @(posedge clock);
        #2;
        start_pin = 1'b1;
        repeat (500) @(posedge clock);
        #2;
        start_pin = 1'b0;
    endtask
endmodule // ebsc_host

// ===== verification/ebsc_top_sva.sv
// Purpose: port checks for the state controller
// Assumes: top module ports only, one clock
// Notes: bound into the top after the module
`timescale 1ns/1ns
module ebsc_top_sva (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [6:0] reg_addr,
    input wire logic [7:0] rd_data,
    input wire logic battery_low,
    input wire logic power_good,
    input wire logic supply_from_battery,
    input wire logic boost_enable,
    input wire logic [2:0] boost_current,
    input wire logic regulator_enable
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    // Battery below floor long enough to clear the synchronizer
    sequence s_low_held;
        battery_low [*6];
    endsequence
    // First edge out of reset
    sequence s_boot;
        $rose(rst_n);
    endsequence
    chk_pg_in_active: assert property (power_good |-> regulator_enable || $past(regulator_enable))
        else $error("ready high outside active state");
    chk_boot_outputs: assert property (s_boot |-> supply_from_battery && !power_good)
        else $error("wrong outputs out of reset");
    chk_startup_idle: assert property (s_boot |-> !boost_enable [*8])
        else $error("boost during startup");
    chk_supply_swap: assert property (supply_from_battery != regulator_enable)
        else $error("supply path and regulator disagree");
    chk_boost_active: assert property (boost_enable |-> !regulator_enable)
        else $error("boost while active");
    chk_current_clamp: assert property (boost_current <= 3'h4)
        else $error("charge current code above emergency");
    chk_floor_pause: assert property (s_low_held |-> !boost_enable)
        else $error("charging while battery below floor");
    chk_unmapped_zero: assert property (reg_addr == 7'h01 |=> rd_data == 8'h00)
        else $error("unmapped read not zero");
endmodule // ebsc_top_sva
bind ebsc_top ebsc_top_sva u_ebsc_top_sva (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
    .rd_data(rd_data), .battery_low(battery_low), .power_good(power_good),
    .supply_from_battery(supply_from_battery), .boost_enable(boost_enable),
    .boost_current(boost_current), .regulator_enable(regulator_enable));

// ===== verification/ebsc_top_tb.sv
// Purpose: self-checking bench for the state controller
// Assumes: short startup and warning counts
// Notes: analog compare results driven directly
`timescale 1ns/1ns
module ebsc_top_tb;
    localparam int STARTUP = 20;
    logic clock, rst_n, wr_en, start_pin, battery_low, regulated_ok;
    logic [6:0] reg_addr;
    logic [7:0] wr_data, rd_data;
    logic [4:0] storage_code;
    logic [3:0] learned_target, charge_target, regulator_level;
    logic power_good, supply_from_battery, boost_enable, regulator_enable;
    logic [2:0] boost_current, floor_level;
    int n_mismatch = 0;
    int tests_run = 0;
    int cycles = 0;
    ebsc_top #(.STARTUP_CYCLES(STARTUP), .WARN_CYCLES(5)) u_ebsc_top (.clock(clock),
        .rst_n(rst_n), .wr_en(wr_en), .reg_addr(reg_addr), .wr_data(wr_data),
        .rd_data(rd_data), .start_pin(start_pin), .battery_low(battery_low),
        .storage_code(storage_code), .learned_target(learned_target),
        .regulated_ok(regulated_ok), .power_good(power_good),
        .supply_from_battery(supply_from_battery), .boost_enable(boost_enable),
        .boost_current(boost_current), .charge_target(charge_target),
        .regulator_enable(regulator_enable), .regulator_level(regulator_level),
        .floor_level(floor_level));
    ebsc_host u_ebsc_host (.clock(clock), .rd_data(rd_data), .wr_en(wr_en),
        .reg_addr(reg_addr), .wr_data(wr_data), .start_pin(start_pin));
    // Clock source
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    // Hang guard
    always @(posedge clock) begin
        cycles++;
        if (cycles == 40000) begin
            n_mismatch++;
            close_out();
        end
    end
    task automatic close_out();
        if (n_mismatch == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Bounded wait on boost (0), regulator (1) or power_good (2)
    task automatic wait_on(input int s, input logic v, input string nm);
        logic x;
        for (int i = 0; i < 2000; i++) begin
            @(posedge clock);
            #2;
            x = (s == 0) ? boost_enable : (s == 1) ? regulator_enable : power_good;
            if (x === v) break;
        end
        chk(nm, {7'h0, v}, {7'h0, x});
    endtask
    task automatic t_boot();
        logic [7:0] d;
        u_ebsc_host.boot(STARTUP);
        chk("supply", 8'h01, {7'h0, supply_from_battery});
        u_ebsc_host.rd(7'h00, d);
        chk("ready_bit", 8'h00, d & 8'h01);
        u_ebsc_host.rd(7'h01, d);
        chk("unmapped", 8'h00, d);
        u_ebsc_host.wr(7'h09, 8'h03);
        u_ebsc_host.wr(7'h0a, 8'h85);
        u_ebsc_host.wr(7'h0b, 8'h6f);
        chk("pg_standby", 8'h00, {7'h0, power_good});
    endtask
    task automatic t_demand(input logic [7:0] cmd, input logic [4:0] code,
        input logic [3:0] tgt);
        logic [7:0] d;
        storage_code = 5'h00;
        u_ebsc_host.wr(7'h08, cmd);
        wait_on(0, 1'b1, "boost_on");
        chk("current", 8'h04, {5'h0, boost_current});
        chk("floor", 8'h05, {5'h0, floor_level});
        chk("target", {4'h0, tgt}, {4'h0, charge_target});
        battery_low = 1'b1;
        wait_on(0, 1'b0, "boost_paused");
        repeat (900) @(posedge clock);
        u_ebsc_host.rd(7'h00, d);
        chk("weak", 8'h10, d & 8'h10);
        battery_low = 1'b0;
        wait_on(0, 1'b1, "boost_resumed");
        chk("in_charge", 8'h00, {7'h0, regulator_enable});
        regulated_ok = 1'b0;
        storage_code = code;
        wait_on(1, 1'b1, "active");
        chk("supply_act", 8'h00, {7'h0, supply_from_battery});
        repeat (4) @(posedge clock);
        #2;
        chk("pg_unregulated", 8'h00, {7'h0, power_good});
        regulated_ok = 1'b1;
        wait_on(2, 1'b1, "pg_high");
        chk("level", 8'h03, {4'h0, regulator_level});
        u_ebsc_host.rd(7'h05, d);
        chk("cap_code", {3'h0, code}, d);
        u_ebsc_host.wr(7'h08, cmd & 8'hfe);
        wait_on(1, 1'b0, "standby");
    endtask
    task automatic t_cont();
        logic [7:0] d;
        storage_code = 5'h00;
        u_ebsc_host.wr(7'h08, 8'h02);
        wait_on(0, 1'b1, "cont_charge");
        storage_code = 5'h16;
        repeat (20) @(posedge clock);
        chk("cont_stays", 8'h00, {7'h0, regulator_enable});
        u_ebsc_host.wr(7'h08, 8'h06);
        wait_on(1, 1'b1, "cont_active");
        wait_on(2, 1'b1, "cont_pg");
        storage_code = 5'h0a;
        u_ebsc_host.rd(7'h00, d);
        chk("warn_off", 8'h00, d & 8'h40);
        u_ebsc_host.wr(7'h0c, 8'h20);
        wait_on(2, 1'b0, "pg_pulse");
        wait_on(2, 1'b1, "pg_back");
        u_ebsc_host.rd(7'h00, d);
        chk("warn_on", 8'h40, d & 8'h40);
        u_ebsc_host.wr(7'h08, 8'h02);
        wait_on(0, 1'b1, "back_charge");
        u_ebsc_host.wr(7'h08, 8'h00);
        wait_on(0, 1'b0, "cont_standby");
    endtask
    task automatic t_force();
        storage_code = 5'h00;
        u_ebsc_host.wr(7'h08, 8'h01);
        wait_on(0, 1'b1, "od_charge");
        u_ebsc_host.wr(7'h08, 8'h05);
        wait_on(1, 1'b1, "forced");
        u_ebsc_host.wr(7'h08, 8'h00);
        wait_on(1, 1'b0, "od_standby");
    endtask
    task automatic t_auto();
        u_ebsc_host.wr(7'h0b, 8'hef);
        u_ebsc_host.wr(7'h0a, 8'he5);
        chk("auto_idle", 8'h00, {7'h0, boost_enable});
        u_ebsc_host.pulse();
        wait_on(0, 1'b1, "auto_charge");
        chk("clamp", 8'h04, {5'h0, boost_current});
    endtask
    // Main sequence
    initial begin
        rst_n = 1'b0;
        battery_low = 1'b0;
        storage_code = 5'h00;
        learned_target = 4'h3;
        regulated_ok = 1'b1;
        repeat (3) @(posedge clock);
        #2 rst_n = 1'b1;
        t_boot();
        t_demand(8'h01, 5'h16, 4'hb);
        t_demand(8'h11, 5'h06, 4'h3);
        t_cont();
        t_force();
        t_auto();
        close_out();
    end
endmodule // ebsc_top_tb
